// ### rtl/pwm_enc_pkg.sv
package pwm_enc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] HIGH_PATTERN_ADDR = 8'h54;
  localparam logic [7:0] LOW_PATTERN_ADDR = 8'h50;
  localparam logic [7:0] LEVEL_CTRL_ADDR = 8'h58;
  localparam logic [7:0] STATUS_ADDR = 8'h5C;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int CNT_W = 7;
  localparam int LC_LSB = 0;
  localparam int HC_LSB = 7;
  localparam int TB_LSB = 14;
  localparam int TB_W = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] HIGH_PATTERN_RST = 16'h3F80;
  localparam logic [15:0] LOW_PATTERN_RST = 16'h007F;

  // ----------------------------------------
  // Time base terminal counts, one less than the period in master clock periods
  // ----------------------------------------
  localparam int TB_MAX_W = 10;
  localparam logic [TB_MAX_W-1:0] TB_DIV_16 = 10'h00F;
  localparam logic [TB_MAX_W-1:0] TB_DIV_64 = 10'h03F;
  localparam logic [TB_MAX_W-1:0] TB_DIV_256 = 10'h0FF;
  localparam logic [TB_MAX_W-1:0] TB_DIV_1024 = 10'h3FF;

  // Terminal count of the time-base divider for a selection
  function automatic logic [TB_MAX_W-1:0] tb_terminal(input logic [TB_W-1:0] sel);
    logic [TB_MAX_W-1:0] t;
    t = TB_DIV_16;
    unique case (sel)
      2'h0: t = TB_DIV_16;
      2'h1: t = TB_DIV_64;
      2'h2: t = TB_DIV_256;
      2'h3: t = TB_DIV_1024;
    endcase
    return t;
  endfunction : tb_terminal

endpackage : pwm_enc_pkg

// ### rtl/time_base_div.sv
`timescale 1ns/1ns
module time_base_div
  import pwm_enc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic [TB_W-1:0] sel,
  input wire logic restart,
  // Tick
  output logic tick
);

  logic [TB_MAX_W-1:0] cnt_q;
  logic [TB_MAX_W-1:0] cnt_d;
  logic tick_q;
  wire logic at_end;

  // One tick every 16, 64, 256 or 1024 master clocks
  assign at_end = (cnt_q >= tb_terminal(sel));
  // Restart loads one so the first tick lands a full time base later
  assign cnt_d = restart ? 10'h001 : (at_end ? '0 : cnt_q + 10'h001);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= at_end && !restart;
    end
  end

  assign tick = tick_q;

endmodule : time_base_div

// ### rtl/level_pwm_core.sv
`timescale 1ns/1ns
module level_pwm_core
  import pwm_enc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pattern
  input wire logic [CNT_W-1:0] high_count,
  input wire logic [CNT_W-1:0] low_count,
  input wire logic tick,
  input wire logic restart,
  // Waveform
  output logic wave,
  output logic in_high_phase
);

  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10
  } phase_t;

  phase_t phase_q;
  phase_t phase_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic wave_q;
  wire logic static_low;
  wire logic static_high;
  wire logic phase_done;

  // Zero high count is static low, even when low count is zero too
  assign static_low = (high_count == '0);
  assign static_high = !static_low && (low_count == '0);
  assign phase_done = tick && (cnt_q == ((phase_q == PH_HIGH) ? high_count : low_count)
                               - 7'h01);

  // Period is high count plus low count ticks
  always_comb
  begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    if (restart || static_low || static_high)
    begin
      phase_d = PH_HIGH;
      cnt_d = '0;
    end
    else if (phase_done)
    begin
      phase_d = (phase_q == PH_HIGH) ? PH_LOW : PH_HIGH;
      cnt_d = '0;
    end
    else if (tick)
    begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_q <= PH_HIGH;
      cnt_q <= '0;
      wave_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      wave_q <= static_low ? 1'b0 : (static_high ? 1'b1 : (phase_d == PH_HIGH));
    end
  end

  assign wave = wave_q;
  assign in_high_phase = (phase_q == PH_HIGH);

endmodule : level_pwm_core

// ### rtl/fault_pin_pwm_level_encoder.sv
`timescale 1ns/1ns
module fault_pin_pwm_level_encoder
  import pwm_enc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin
  output logic fault_output_pin
);

  // ----------------------------------------
  // Pattern registers
  // ----------------------------------------
  logic [15:0] high_pat_q;
  logic [15:0] high_pat_d;
  logic [15:0] low_pat_q;
  logic [15:0] low_pat_d;

  // ----------------------------------------
  // Level and restart
  // ----------------------------------------
  logic level_q;
  logic level_d;
  logic restart_q;
  logic restart_d;

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // ----------------------------------------
  // Pin
  // ----------------------------------------
  logic pin_q;
  logic pin_d;

  // ----------------------------------------
  // Engine
  // ----------------------------------------
  wire logic tick;
  wire logic wave;
  wire logic in_high;

  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Setup launches the answer; only the access edge commits a write
  wire logic setup = psel && !penable;
  wire logic access = psel && penable && pready_q;
  wire logic rd_setup = setup && !pwrite;
  wire logic wr_access = access && pwrite;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic hit_high = (paddr == HIGH_PATTERN_ADDR);
  wire logic hit_low = (paddr == LOW_PATTERN_ADDR);
  wire logic hit_ctrl = (paddr == LEVEL_CTRL_ADDR);
  wire logic hit_stat = (paddr == STATUS_ADDR);
  wire logic mapped = hit_high || hit_low || hit_ctrl || hit_stat;

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  wire logic wr = wr_access && mapped;
  wire logic wr_high = wr && hit_high;
  wire logic wr_low = wr && hit_low;
  wire logic wr_ctrl = wr && hit_ctrl;

  // ----------------------------------------
  // Written fields
  // ----------------------------------------
  // Reserved bits 15:14 of the high pattern read zero
  wire logic [15:0] high_pat_wr = {2'b00, pwdata[13:0]};
  wire logic [15:0] low_pat_wr = pwdata[15:0];
  wire logic level_wr = pwdata[0];

  // ----------------------------------------
  // Stored fields
  // ----------------------------------------
  wire logic [CNT_W-1:0] high_level_high_count = high_pat_q[HC_LSB +: CNT_W];
  wire logic [CNT_W-1:0] high_level_low_count = high_pat_q[LC_LSB +: CNT_W];
  wire logic [CNT_W-1:0] low_level_high_count = low_pat_q[HC_LSB +: CNT_W];
  wire logic [CNT_W-1:0] low_level_low_count = low_pat_q[LC_LSB +: CNT_W];
  // One time base serves both levels, so a level swap keeps the rate
  wire logic [TB_W-1:0] pattern_time_base_select = low_pat_q[TB_LSB +: TB_W];

  // ----------------------------------------
  // Pattern select
  // ----------------------------------------
  wire logic [CNT_W-1:0] sel_high_cnt = level_q ? high_level_high_count
                                                : low_level_high_count;
  wire logic [CNT_W-1:0] sel_low_cnt = level_q ? high_level_low_count
                                               : low_level_low_count;

  // ----------------------------------------
  // Restart
  // ----------------------------------------
  // Pattern change restarts cleanly rather than finishing a stale period
  wire logic level_change = wr_ctrl && (level_wr != level_q);
  wire logic change = wr_high || wr_low || level_change;

  // ----------------------------------------
  // Time base and waveform
  // ----------------------------------------
  time_base_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .sel(pattern_time_base_select),
    .restart(restart_q),
    .tick(tick)
  );

  level_pwm_core u_core (
    .sys_clk(sys_clk),
    .rst(rst),
    .high_count(sel_high_cnt),
    .low_count(sel_low_cnt),
    .tick(tick),
    .restart(restart_q),
    .wave(wave),
    .in_high_phase(in_high)
  );

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  wire logic stat_level = level_q;
  wire logic stat_wave = wave;
  wire logic stat_phase = in_high;

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  wire logic [31:0] rd_high = {16'h0000, high_pat_q};
  wire logic [31:0] rd_low = {16'h0000, low_pat_q};
  wire logic [31:0] rd_ctrl = {31'h0, level_q};
  wire logic [31:0] rd_stat = {29'h0, stat_phase, stat_wave, stat_level};
  wire logic [31:0] rd_mux =
    hit_high ? rd_high :
    hit_low ? rd_low :
    hit_ctrl ? rd_ctrl :
    hit_stat ? rd_stat : 32'h0000_0000;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  assign high_pat_d = wr_high ? high_pat_wr : high_pat_q;
  assign low_pat_d = wr_low ? low_pat_wr : low_pat_q;
  assign level_d = wr_ctrl ? level_wr : level_q;
  assign restart_d = change;
  // No wait state: the answer is registered from the setup cycle
  assign pready_d = setup;
  assign pslverr_d = setup && !mapped;
  assign prdata_d = rd_setup ? rd_mux : 32'h0000_0000;
  assign pin_d = wave;

  // ----------------------------------------
  // High-level pattern register
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      high_pat_q <= HIGH_PATTERN_RST;
    end
    else
    begin
      high_pat_q <= high_pat_d;
    end
  end

  // ----------------------------------------
  // Low-level pattern register
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      low_pat_q <= LOW_PATTERN_RST;
    end
    else
    begin
      low_pat_q <= low_pat_d;
    end
  end

  // ----------------------------------------
  // Level control
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      level_q <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
    end
  end

  // ----------------------------------------
  // Restart strobe
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      restart_q <= 1'b1;
    end
    else
    begin
      restart_q <= restart_d;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata_q <= '0;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Pin register
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fault_output_pin = pin_q;

endmodule : fault_pin_pwm_level_encoder

// ### tb/pin_props.sv
`timescale 1ns/1ns
module pin_props
  import pwm_enc_pkg::*;
(
  // Encoder top ports
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_output_pin
);
  // ----------------
  // Shadow state
  // ----------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic lvl_q;
  int run_q;
  int quiet_q;
  wire wr = psel && penable && pready && pwrite;
  wire [15:0] pat = lvl_q ? hi_q : lo_q;
  wire [6:0] hc = pat[13:7];
  wire [6:0] lc = pat[6:0];
  wire [31:0] tbm = 32'h10 << (2 * lo_q[15:14]);
  wire mapped = paddr[7:4] == 4'h5 && paddr[1:0] == 2'h0;
  always_ff @(posedge sys_clk)
  begin
    run_q <= $changed(fault_output_pin) ? 1 : run_q + 1;
    // Runs that began before a restart are not judged
    quiet_q <= (rst || wr) ? 0 : quiet_q + 1;
    if (rst) lo_q <= LOW_PATTERN_RST;
    else if (wr && paddr == LOW_PATTERN_ADDR) lo_q <= pwdata[15:0];
    if (rst) hi_q <= HIGH_PATTERN_RST;
    else if (wr && paddr == HIGH_PATTERN_ADDR) hi_q <= {2'h0, pwdata[13:0]};
    if (rst) lvl_q <= 1'b0;
    else if (wr && paddr == LEVEL_CTRL_ADDR) lvl_q <= pwdata[0];
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence settled_s;
    quiet_q > run_q + 3;
  endsequence
  high_time_a:
    assert property (settled_s ##0 $fell(fault_output_pin) |-> run_q == hc * tbm)
    else $error("high run wrong");
  low_time_a:
    assert property (settled_s ##0 $rose(fault_output_pin) |-> run_q == lc * tbm)
    else $error("low run wrong");
  static_low_a:
    assert property (quiet_q > 3 && hc == 7'h00 |-> !fault_output_pin)
    else $error("pin not static low");
  static_high_a:
    assert property (quiet_q > 3 && hc != 7'h00 && lc == 7'h00 |-> fault_output_pin)
    else $error("pin not static high");
  ready_once_a:
    assert property (setup_s |=> pready ##1 !pready)
    else $error("ready not one cycle");
  ready_cause_a:
    assert property (pready |-> $past(psel && !penable))
    else $error("stray ready");
  slverr_map_a:
    assert property (pready |-> pslverr == !mapped)
    else $error("slave error wrong");
  read_back_a:
    assert property (pready && !pwrite && paddr == HIGH_PATTERN_ADDR |-> prdata == hi_q)
    else $error("pattern readback wrong");
endmodule : pin_props

bind fault_pin_pwm_level_encoder pin_props i_pin_props (.sys_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_output_pin);

// ### tb/pin_decoder.sv
`timescale 1ns/1ns
module pin_decoder
(
  // Clock and pin
  input wire logic sys_clk,
  input wire logic pin,
  // Last runs, in clocks
  output int high_len,
  output int low_len
);
  int run_q = 0;
  logic last_q = 1'b0;
  always_ff @(posedge sys_clk)
  begin
    last_q <= pin;
    run_q <= (pin === last_q) ? run_q + 1 : 1;
    if (pin !== last_q && last_q) high_len <= run_q;
    if (pin !== last_q && !last_q) low_len <= run_q;
  end
endmodule : pin_decoder

// ### tb/tb_fault_pin_pwm_level_encoder.sv
`timescale 1ns/1ns
module tb_fault_pin_pwm_level_encoder
  import pwm_enc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdata;
  logic err;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_output_pin;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'h5FD7;
  int hi_len;
  int lo_len;
  logic [15:0] lo_m = LOW_PATTERN_RST;
  logic [15:0] hi_m = HIGH_PATTERN_RST;
  fault_pin_pwm_level_encoder i_fault_pin_pwm_level_encoder (.sys_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_output_pin);
  pin_decoder i_pin_decoder (.sys_clk, .pin(fault_output_pin), .high_len(hi_len),
    .low_len(lo_len));
  initial forever #50 sys_clk = ~sys_clk;
  // ----------------
  // Tasks
  // ----------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("BAD %s exp %0h got %0h", what, exp, got);
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
    if (n == 50) n_mismatch++;
    if (n == 50) close_out();
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never lands on the release
    @(posedge sys_clk);
  endtask : apb
  task automatic measure(input logic lvl, input logic [15:0] pat);
    logic [15:0] p;
    int m;
    int h;
    int l;
    if (lvl) hi_m = pat & 16'h3FFF;
    else lo_m = pat;
    apb(1'b1, lvl ? HIGH_PATTERN_ADDR : LOW_PATTERN_ADDR, {16'h0, pat});
    apb(1'b1, LEVEL_CTRL_ADDR, {31'h0, lvl});
    p = lvl ? hi_m : lo_m;
    m = 16 << (2 * lo_m[15:14]);
    h = p[13:7] * m;
    l = p[6:0] * m;
    repeat (2 * (h + l) + 40) @(posedge sys_clk);
    if (h == 0 || l == 0) chk("static pin", {31'h0, h != 0}, {31'h0, fault_output_pin});
    else chk("high time", h, hi_len);
    if (h != 0 && l != 0) chk("low time", l, lo_len);
  endtask : measure
  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, HIGH_PATTERN_ADDR, 32'h0);
    chk("high reg", 32'h3F80, rdata);
    chk("ok err", 32'h0, {31'h0, err});
    apb(1'b0, LOW_PATTERN_ADDR, 32'h0);
    chk("low reg", 32'h007F, rdata);
    apb(1'b0, 8'h60, 32'h0);
    chk("bad err", 32'h1, {31'h0, err});
    chk("bad data", 32'h0, rdata);
    measure(1'b0, 16'h007F);
    for (int t = 3; t >= 0; t--) measure(1'b0, 16'(t << 14) | 16'h0081);
    apb(1'b1, HIGH_PATTERN_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, HIGH_PATTERN_ADDR, 32'h0);
    chk("reserved", 32'h3FFF, rdata);
    measure(1'b1, 16'h0105);
    measure(1'b1, 16'h0003);
    measure(1'b1, 16'h0200);
    measure(1'b1, 16'h0000);
    measure(1'b0, 16'h0180);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", 32'h6, rdata);
    apb(1'b0, LEVEL_CTRL_ADDR, 32'h0);
    chk("level reg", 32'h0, rdata);
    repeat (8) measure(1'($random(seed)), 16'($random(seed)) & 16'h0387);
    close_out();
  end
endmodule : tb_fault_pin_pwm_level_encoder
